// ==== inc/sadc_defs.vh ====
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH
// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define SADC_SCS_ADDR 12'h038
`define SADC_DATA_ADDR 12'h03C
`define SADC_CLK_ADDR 12'h040
`define SADC_CTRL_ADDR 12'h044
// ------------------------------------------------------------
// Field positions and values
// ------------------------------------------------------------
`define SADC_DONE_BIT 7
`define SADC_IRQEN_BIT 6
`define SADC_CONT_BIT 5
`define SADC_CH_HI 4
`define SADC_CH_OFF 5'h1F
`define SADC_CH_MAX 5'h0E
`define SADC_CH_REFH 5'h1D
`define SADC_CH_REFL 5'h1E
`define SADC_NCH 15
`define SADC_SRC_BIT 4
`define SADC_DIV_HI 7
`define SADC_DIV_LO 5
`define SADC_SCS_RST 8'h1F
`define SADC_CLK_RST 8'h00
`define SADC_XTAL_DIV 4'h3
`define SADC_STEPS 4'h8
`define SADC_SETTLE 8'h08
`define SADC_BUSY_BIT 0
`define SADC_PWR_BIT 1
`define SADC_STOP_BIT 2
`endif

// ==== src/sadc_clkdiv.v ====
`timescale 1ns/1ps
`include "sadc_defs.vh"
module sadc_clkdiv (
   input wire core_clk_i,
   input wire rst_i,
   input wire clear_i,
   input wire src_bus_i,
   input wire [2:0] div_i,
   output reg tick_o
);
   reg [3:0] xtal_cnt_r;
   reg [4:0] div_cnt_r;
   reg [4:0] limit;
   wire in_tick;
   // ------------------------------------------------------------
   // Input clock source: bus clock or slower crystal reference
   // ------------------------------------------------------------
   assign in_tick = src_bus_i | (xtal_cnt_r == `SADC_XTAL_DIV);
   always @* begin
      case (div_i)
         3'h0: limit = 5'h01;
         3'h1: limit = 5'h02;
         3'h2: limit = 5'h04;
         3'h3: limit = 5'h08;
         default: limit = 5'h10;
      endcase
   end
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         xtal_cnt_r <= 4'h0;
         div_cnt_r <= 5'h00;
         tick_o <= 1'b0;
      end else begin
         xtal_cnt_r <= (xtal_cnt_r == `SADC_XTAL_DIV) ? 4'h0 : xtal_cnt_r + 4'h1;
         tick_o <= 1'b0;
         if (clear_i) begin
            div_cnt_r <= 5'h00;
         end else if (in_tick) begin
            if (div_cnt_r + 5'h01 >= limit) begin
               div_cnt_r <= 5'h00;
               tick_o <= 1'b1;
            end else begin
               div_cnt_r <= div_cnt_r + 5'h01;
            end
         end
      end
   end
endmodule

// ==== src/sadc_seq.v ====
`timescale 1ns/1ps
`include "sadc_defs.vh"
module sadc_seq (
   input wire core_clk_i,
   input wire rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   input wire stop_mode_i,
   input wire wait_mode_i,
   input wire cmp_high_i,
   input wire [14:0] port_out_latch_i,
   input wire [14:0] port_dir_i,
   input wire [14:0] pin_in_i,
   output reg [14:0] pin_out_o,
   output reg [14:0] pin_oe_o,
   output reg [14:0] pin_read_o,
   output reg [14:0] analog_sel_o,
   output reg [4:0] selected_analog_input_o,
   output reg [7:0] dac_code_o,
   output reg conv_power_o,
   output reg conv_irq_o,
   output reg wake_req_o
);
   localparam S_IDLE = 3'b001;
   localparam S_SAMPLE = 3'b010;
   localparam S_CONV = 3'b100;
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg [7:0] scs_r;
   reg [7:0] clk_r;
   reg [7:0] data_r;
   reg [7:0] sar_r;
   reg [3:0] step_r;
   reg [2:0] state_r;
   reg done_r;
   reg irq_r;
   reg stop_s1_r;
   reg stop_s2_r;
   reg cmp_s1_r;
   reg cmp_s2_r;
   reg [7:0] settle_r;
   reg abort_r;
   reg [14:0] pin_s1_r;
   reg [14:0] pin_s2_r;
   reg [7:0] sar_nxt;
   wire access;
   wire wr_scs;
   wire rd_data;
   wire tick;
   wire power_on;
   wire [4:0] ch;
   wire [7:0] trial;
   assign access = psel_i & penable_i;
   assign wr_scs = access & pwrite_i & (paddr_i == `SADC_SCS_ADDR);
   assign rd_data = access & ~pwrite_i & (paddr_i == `SADC_DATA_ADDR);
   assign ch = scs_r[`SADC_CH_HI:0];
   assign power_on = (ch != `SADC_CH_OFF);
   assign trial = sar_r | (8'h80 >> step_r[2:0]);
   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         stop_s1_r <= 1'b0;
         stop_s2_r <= 1'b0;
         cmp_s1_r <= 1'b0;
         cmp_s2_r <= 1'b0;
         pin_s1_r <= 15'h0000;
         pin_s2_r <= 15'h0000;
      end else begin
         stop_s1_r <= stop_mode_i;
         stop_s2_r <= stop_s1_r;
         cmp_s1_r <= cmp_high_i;
         cmp_s2_r <= cmp_s1_r;
         pin_s1_r <= pin_in_i;
         pin_s2_r <= pin_s1_r;
      end
   end
   sadc_clkdiv u_div (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .clear_i(wr_scs),
      .src_bus_i(clk_r[`SADC_SRC_BIT]),
      .div_i(clk_r[`SADC_DIV_HI:`SADC_DIV_LO]),
      .tick_o(tick)
   );
   // ------------------------------------------------------------
   // Successive approximation sequencer
   // ------------------------------------------------------------
   always @* begin
      sar_nxt = cmp_s2_r ? sar_r : trial;
   end
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= S_IDLE;
         sar_r <= 8'h00;
         step_r <= 4'h0;
         data_r <= 8'h00;
         done_r <= 1'b0;
         irq_r <= 1'b0;
         settle_r <= 8'h00;
         abort_r <= 1'b0;
      end else begin
         if (stop_s2_r) begin
            state_r <= S_IDLE;
            settle_r <= `SADC_SETTLE;
            if (state_r != S_IDLE) begin
               abort_r <= 1'b1;
            end
         end else if (wr_scs) begin
            state_r <= S_SAMPLE;
            abort_r <= 1'b0;
            sar_r <= 8'h00;
            step_r <= 4'h0;
         end else begin
            if (tick && settle_r != 8'h00) begin
               settle_r <= settle_r - 8'h01;
            end
            case (state_r)
               S_IDLE: begin
                  // Aborted conversion restarts once stop ends
                  if (abort_r && power_on) begin
                     state_r <= S_SAMPLE;
                     sar_r <= 8'h00;
                     step_r <= 4'h0;
                     abort_r <= 1'b0;
                  end
               end
               S_SAMPLE: begin
                  if (!power_on) begin
                     state_r <= S_IDLE;
                  end else if (tick) begin
                     if (step_r == `SADC_STEPS) begin
                        step_r <= 4'h0;
                        state_r <= S_CONV;
                     end else begin
                        step_r <= step_r + 4'h1;
                     end
                  end
               end
               S_CONV: begin
                  if (tick) begin
                     sar_r <= sar_nxt;
                     if (step_r == `SADC_STEPS - 4'h1) begin
                        data_r <= sar_nxt;
                        sar_r <= 8'h00;
                        step_r <= 4'h0;
                        state_r <= scs_r[`SADC_CONT_BIT] ? S_SAMPLE : S_IDLE;
                     end else begin
                        step_r <= step_r + 4'h1;
                     end
                  end
               end
               default: state_r <= S_IDLE;
            endcase
         end
         // Done flag and interrupt, set wins over a data read clear, a status write wins over set
         if (state_r == S_CONV && tick && step_r == `SADC_STEPS - 4'h1 && !wr_scs
             && !stop_s2_r) begin
            if (scs_r[`SADC_IRQEN_BIT]) begin
               irq_r <= 1'b1;
            end else begin
               done_r <= 1'b1;
            end
         end else if (wr_scs || rd_data) begin
            irq_r <= 1'b0;
            done_r <= (wr_scs && scs_r[`SADC_IRQEN_BIT]) ?
               pwdata_i[`SADC_DONE_BIT] : 1'b0;
         end
      end
   end
   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         scs_r <= `SADC_SCS_RST;
         clk_r <= `SADC_CLK_RST;
      end else if (access && pwrite_i) begin
         if (paddr_i == `SADC_SCS_ADDR) begin
            scs_r <= {1'b0, pwdata_i[6:0]};
         end
         if (paddr_i == `SADC_CLK_ADDR) begin
            clk_r <= {pwdata_i[7:4], 4'h0};
         end
      end
   end
   // ------------------------------------------------------------
   // APB slave, one wait-free access phase
   // ------------------------------------------------------------
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_o <= 32'h00000000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= psel_i & ~penable_i;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h00000000;
         if (psel_i && !penable_i) begin
            case (paddr_i)
               `SADC_SCS_ADDR: prdata_o <= {24'h000000, done_r, scs_r[6:0]};
               `SADC_DATA_ADDR: prdata_o <= {24'h000000, data_r};
               `SADC_CLK_ADDR: prdata_o <= {24'h000000, clk_r};
               `SADC_CTRL_ADDR: prdata_o <= {24'h000000, settle_r[7:3], stop_s2_r,
                                              power_on, state_r != S_IDLE};
               default: pslverr_o <= 1'b1;
            endcase
         end
      end
   end
   // ------------------------------------------------------------
   // Pin ownership and analog mux
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `SADC_NCH; gi = gi + 1) begin : g_pin
         wire taken = (ch == gi);
         always @(posedge core_clk_i or posedge rst_i) begin
            if (rst_i) begin
               analog_sel_o[gi] <= 1'b0;
               pin_oe_o[gi] <= 1'b0;
               pin_out_o[gi] <= 1'b0;
               pin_read_o[gi] <= 1'b0;
            end else begin
               analog_sel_o[gi] <= taken;
               pin_oe_o[gi] <= ~taken & port_dir_i[gi];
               pin_out_o[gi] <= port_out_latch_i[gi];
               pin_read_o[gi] <= taken ? (port_dir_i[gi] & port_out_latch_i[gi]) :
                  (port_dir_i[gi] ? port_out_latch_i[gi] : pin_s2_r[gi]);
            end
         end
      end
   endgenerate
   // ------------------------------------------------------------
   // Converter side outputs
   // ------------------------------------------------------------
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         selected_analog_input_o <= `SADC_CH_OFF;
         dac_code_o <= 8'h00;
         conv_power_o <= 1'b0;
         conv_irq_o <= 1'b0;
         wake_req_o <= 1'b0;
      end else begin
         selected_analog_input_o <= ch;
         dac_code_o <= (state_r == S_CONV) ? trial : 8'h00;
         conv_power_o <= power_on & ~stop_s2_r;
         conv_irq_o <= irq_r;
         wake_req_o <= irq_r & wait_mode_i;
      end
   end
endmodule

// ==== tb/sadc_seq_monitor.sv ====
`timescale 1ns/1ps
`include "sadc_defs.vh"
// ----
// Port checker
// ----
module sadc_seq_monitor (
   input wire core_clk_i,
   input wire rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   input wire stop_mode_i,
   input wire [14:0] port_dir_i,
   input wire [14:0] pin_oe_o,
   input wire [14:0] pin_read_o,
   input wire [14:0] analog_sel_o,
   input wire [4:0] selected_analog_input_o,
   input wire conv_power_o,
   input wire conv_irq_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] since_wr_r;
   wire scs_wr = psel_i && penable_i && pwrite_i && paddr_i == `SADC_SCS_ADDR;
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         since_wr_r <= 8'h00;
      end else if (scs_wr) begin
         since_wr_r <= 8'h00;
      end else if (since_wr_r != 8'hFF) begin
         since_wr_r <= since_wr_r + 8'h01;
      end
   end
   a_sel_one_hot: assert property ($onehot0(analog_sel_o))
      else $error("mux select not one-hot");
   a_sel_from_code: assert property (selected_analog_input_o <= 5'h0E |->
      analog_sel_o == (15'h0001 << selected_analog_input_o))
      else $error("mux select disagrees with channel code");
   a_taken_no_drive: assert property ((analog_sel_o & pin_oe_o) == 15'h0000)
      else $error("selected pin still driven");
   a_taken_reads_zero: assert property ($stable(port_dir_i) && $stable(analog_sel_o) |->
      (pin_read_o & analog_sel_o & ~port_dir_i) == 15'h0000)
      else $error("taken input pin reads nonzero");
   a_off_no_power: assert property ($stable(selected_analog_input_o) &&
      selected_analog_input_o == `SADC_CH_OFF |-> !conv_power_o)
      else $error("converter powered while off code selected");
   a_pready_next: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no zero-wait answer");
   a_err_reads_zero: assert property (pslverr_o |-> prdata_o == 32'h0000_0000)
      else $error("refused access returned data");
   a_irq_clr_write: assert property (scs_wr |=> ##1 !conv_irq_o)
      else $error("request not cleared by status write");
   a_irq_not_early: assert property ($rose(conv_irq_o) |-> since_wr_r >= 8'h10)
      else $error("conversion finished too soon");
   a_stop_no_result: assert property (stop_mode_i [*4] |=> !$rose(conv_irq_o))
      else $error("result delivered in stop");
   a_stop_power_off: assert property (stop_mode_i [*3] |=> !conv_power_o)
      else $error("converter powered in stop");
endmodule
bind sadc_seq sadc_seq_monitor mon (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .prdata_o, .pready_o, .pslverr_o, .stop_mode_i, .port_dir_i, .pin_oe_o,
   .pin_read_o, .analog_sel_o, .selected_analog_input_o, .conv_power_o, .conv_irq_o);

// ==== tb/test_sar_adc_sequencer.sv ====
`timescale 1ns/1ps
`include "sadc_defs.vh"
module test_sar_adc_sequencer;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic stop_mode_i = 1'b0, wait_mode_i = 1'b0, err;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000, rd;
   logic [14:0] port_out_latch_i = 15'h3333, port_dir_i = 15'h5555, pin_in_i = 15'h0F0F, m;
   logic [7:0] vin = 8'h00;
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, conv_power_o, conv_irq_o, wake_req_o;
   wire [14:0] pin_out_o, pin_oe_o, pin_read_o, analog_sel_o;
   wire [4:0] selected_analog_input_o;
   wire [7:0] dac_code_o;
   // Comparator: trial code above input
   wire cmp_high_i = dac_code_o > vin;
   int errors = 0;
   int samples_checked = 0;
   sadc_seq dut (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .stop_mode_i, .wait_mode_i, .cmp_high_i,
      .port_out_latch_i, .port_dir_i, .pin_in_i, .pin_out_o, .pin_oe_o, .pin_read_o,
      .analog_sel_o, .selected_analog_input_o, .dac_code_o, .conv_power_o, .conv_irq_o,
      .wake_req_o);
   always #25 core_clk_i = ~core_clk_i;
   // ----
   // Tasks
   // ----
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      rd = prdata_o;
      err = pslverr_o;
      if (n >= 20) begin
         chk(32'h1, 32'h0);
         print_verdict();
      end
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic conv(input logic [7:0] scs, input logic [7:0] v, input int f);
      int n;
      vin <= v;
      apb(1'b1, `SADC_SCS_ADDR, {24'h000000, scs});
      n = 1;
      while (conv_irq_o !== 1'b1 && n < 600) begin
         @(posedge core_clk_i);
         n++;
      end
      chk(n >= 16 * f && n <= 17 * f + 6, 32'h1);
      if (n >= 600) print_verdict();
      chk(wake_req_o, wait_mode_i);
      apb(1'b0, `SADC_DATA_ADDR, 32'h0);
      chk(rd, {24'h000000, v});
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ----
   // Tests
   // ----
   initial begin
      repeat (10) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      apb(1'b0, `SADC_SCS_ADDR, 32'h0);
      chk(rd, 32'h1F);
      chk(conv_power_o, 32'h0);
      apb(1'b0, `SADC_CLK_ADDR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h050, 32'h0);
      chk(err, 32'h1);
      for (int c = 0; c < 15; c++) begin
         m = 15'h0001 << c;
         wait_mode_i <= c[0];
         port_dir_i <= c[1] ? 15'h2AAA : 15'h5555;
         port_out_latch_i <= c[2] ? 15'h4CCC : 15'h3333;
         conv(8'h40 | c[7:0], (c == 14) ? 8'hFF : c[7:0] * 8'h11, 4);
         chk(analog_sel_o, m);
         chk(pin_oe_o, port_dir_i & ~m);
         chk(pin_out_o, port_out_latch_i);
         chk(conv_power_o, 32'h1);
         chk(pin_read_o, (port_dir_i & port_out_latch_i) | (~port_dir_i & pin_in_i & ~m));
      end
      apb(1'b1, `SADC_SCS_ADDR, 32'h1F);
      wait_mode_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      chk(conv_power_o, 32'h0);
      wait_mode_i <= 1'b0;
      apb(1'b1, `SADC_SCS_ADDR, 32'h43);
      repeat (30) @(posedge core_clk_i);
      conv(8'h45, 8'hA5, 4);
      vin <= 8'h3C;
      apb(1'b1, `SADC_SCS_ADDR, 32'h22);
      repeat (80) @(posedge core_clk_i);
      apb(1'b0, `SADC_SCS_ADDR, 32'h0);
      chk(rd[7], 32'h1);
      vin <= 8'hC3;
      repeat (150) @(posedge core_clk_i);
      apb(1'b0, `SADC_SCS_ADDR, 32'h0);
      chk(rd[7], 32'h1);
      apb(1'b0, `SADC_DATA_ADDR, 32'h0);
      chk(rd, 32'hC3);
      // Align to a fresh result so the next one is far off
      do apb(1'b0, `SADC_SCS_ADDR, 32'h0); while (rd[7] !== 1'b1);
      apb(1'b0, `SADC_DATA_ADDR, 32'h0);
      chk(rd, 32'hC3);
      apb(1'b0, `SADC_SCS_ADDR, 32'h0);
      chk(rd[7], 32'h0);
      repeat (80) @(posedge core_clk_i);
      apb(1'b1, `SADC_SCS_ADDR, 32'h02);
      apb(1'b0, `SADC_SCS_ADDR, 32'h0);
      chk(rd[7], 32'h0);
      repeat (80) @(posedge core_clk_i);
      apb(1'b0, `SADC_DATA_ADDR, 32'h0);
      repeat (160) @(posedge core_clk_i);
      apb(1'b0, `SADC_SCS_ADDR, 32'h0);
      chk(rd[7], 32'h0);
      apb(1'b1, `SADC_SCS_ADDR, 32'h44);
      repeat (20) @(posedge core_clk_i);
      stop_mode_i <= 1'b1;
      repeat (120) @(posedge core_clk_i);
      chk(conv_irq_o, 32'h0);
      stop_mode_i <= 1'b0;
      repeat (100) @(posedge core_clk_i);
      chk(conv_irq_o, 32'h1);
      apb(1'b0, `SADC_DATA_ADDR, 32'h0);
      chk(rd, 32'hC3);
      conv(8'h44, 8'h99, 4);
      apb(1'b1, `SADC_SCS_ADDR, 32'hDF);
      apb(1'b0, `SADC_SCS_ADDR, 32'h0);
      chk(rd, 32'hDF);
      // Crystal source for the two fastest settings, bus source after
      for (int k = 0; k < 6; k++) begin
         apb(1'b1, `SADC_CLK_ADDR, {24'h000000, (k == 5) ? 3'h7 : k[2:0], (k > 1), 4'h0});
         conv(8'h43, 8'h5A + k[7:0], (k < 2) ? (4 << k) : (1 << ((k > 4) ? 4 : k)));
      end
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge core_clk_i);
      errors++;
      print_verdict();
   end
endmodule
